// file: src/sdrm_top.sv
// stepper driver register map: status capture, control registers, serial access
// assumes fault detectors deliver synchronous levels and the serial pins are
// sampled by the system clock, which must run well above the serial clock
`timescale 1ns/100ps
`default_nettype none
module sdrm_top
    import sdrm_pkg::*;
#(
    parameter bit         EXTENDED_VARIANT = 1'b0,
    // arbitrary value, not tied to any real part
    parameter logic [3:0] REVISION_CODE    = 4'h1
) (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        SCLK_IN,
    input  wire logic        CHIP_SELECT_N_IN,
    input  wire logic        SERIAL_DATA_IN_IN,
    output logic             SERIAL_DATA_OUT_OUT,
    output logic             SERIAL_DATA_OUT_OE_OUT,
    input  wire logic        SUPPLY_UNDERVOLTAGE_LOCKOUT_IN,
    input  wire logic        CHARGE_PUMP_UNDERVOLTAGE_IN,
    input  wire logic [7:0]  FET_OVERCURRENT_IN,
    input  wire logic        UNDERTEMP_WARNING_IN,
    input  wire logic        OVERTEMP_WARNING_IN,
    input  wire logic        OVERTEMP_SHUTDOWN_IN,
    input  wire logic        STALL_IN,
    input  wire logic        STALL_LEARN_DONE_IN,
    input  wire logic        OPEN_LOAD_BRIDGE_A_IN,
    input  wire logic        OPEN_LOAD_BRIDGE_B_IN,
    input  wire logic [7:0]  TORQUE_COUNT_VALUE_IN,
    output logic             FAULT_N_OUT,
    output logic      [3:0]  TORQUE_SCALE_OUT,
    output logic      [1:0]  SLEW_RATE_OUT,
    output logic             OUTPUT_DISABLE_OUT,
    output logic      [1:0]  PWM_OFF_TIME_OUT,
    output logic      [2:0]  DECAY_MODE_OUT,
    output logic             DIRECTION_OUT,
    output logic             STEP_OUT,
    output logic             SERIAL_DIR_SELECT_OUT,
    output logic             SERIAL_STEP_SELECT_OUT,
    output logic      [2:0]  LOCK_OUT,
    output logic             OPEN_LOAD_ENABLE_OUT,
    output logic             OVERCURRENT_RESPONSE_OUT,
    output logic             OVERTEMP_RESPONSE_OUT,
    output logic             THERMAL_WARN_REPORT_OUT,
    output logic             STALL_LEARN_START_OUT,
    output logic             STALL_DETECT_ENABLE_OUT,
    output logic             STALL_REPORT_ENABLE_OUT,
    output logic      [1:0]  OPEN_LOAD_TIME_OUT,
    output logic             DECAY_DRIVE_BLANKING_ENABLE_OUT,
    output logic      [7:0]  STALL_THRESHOLD_VALUE_OUT
);
    import sdrm_pkg::*;

    localparam logic [7:0] M_STALL_OL  = EXTENDED_VARIANT ? M_STALL_OL_EXT
                                                          : M_STALL_OL_BASE;
    localparam logic [7:0] RST_DECAY   = EXTENDED_VARIANT ? RST_DECAY_EXT
                                                          : RST_DECAY_BASE;

    // merge a write into a register through its writable-bit mask
    function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                                input logic [7:0] new_val,
                                                input logic [7:0] mask);
        masked_write = (old_val & ~mask) | (new_val & mask);
    endfunction : masked_write

    // a flag set in the clearing cycle survives the clear, so no event is lost
    function automatic logic sticky_next(input logic flag_val,
                                         input logic set_val,
                                         input logic clear_val);
        sticky_next = (flag_val & ~clear_val) | set_val;
    endfunction : sticky_next

    logic [4:0]  frame_addr;
    logic        frame_done;
    logic        frame_err;
    logic        read_write_select;
    logic [7:0]  frame_wdata;
    logic [7:0]  status_byte;
    logic [7:0]  report_byte;
    logic        write_strobe;

    // sticky status
    logic        supply_undervoltage_lockout_q, supply_undervoltage_lockout_d;
    logic        charge_pump_undervoltage_q, charge_pump_undervoltage_d;
    logic        serr_q, serr_d;
    logic [7:0]  fet_oc_q, fet_oc_d;
    logic        utw_q, utw_d;
    logic        otw_q, otw_d;
    logic        ots_q, ots_d;
    logic        learn_ok_q, learn_ok_d;
    logic        stall_q, stall_d;
    logic        ol_a_q, ol_a_d;
    logic        ol_b_q, ol_b_d;
    logic        clear_req;

    // control registers
    logic [7:0]  torque_slew_q, torque_slew_d;
    logic [7:0]  decay_off_q, decay_off_d;
    logic [7:0]  step_dir_q, step_dir_d;
    logic [7:0]  protection_q, protection_d;
    logic [7:0]  stall_ol_q, stall_ol_d;
    logic [7:0]  stall_thresh_q, stall_thresh_d;
    logic [7:0]  torque_count_q, torque_count_d;

    // summary terms
    logic        oc_sum;
    logic        temp_sum;
    logic        ol_sum;
    logic        fault_any;
    logic        fault_q, fault_d;
    logic [7:0]  fault_summary;
    logic [7:0]  diag_thermal;

    sdrm_spi_frame u_frame (
        .clk_in                (CLK_SYS_IN),
        .rst_in                (SYS_RST_IN),
        .sclk_in               (SCLK_IN),
        .cs_n_in               (CHIP_SELECT_N_IN),
        .sdi_in                (SERIAL_DATA_IN_IN),
        .status_in             (status_byte),
        .report_in             (report_byte),
        .addr_out              (frame_addr),
        .frame_done_out        (frame_done),
        .frame_err_out         (frame_err),
        .read_write_select_out (read_write_select),
        .wdata_out             (frame_wdata),
        .sdo_out               (SERIAL_DATA_OUT_OUT),
        .sdo_oe_out            (SERIAL_DATA_OUT_OE_OUT)
    );

    // a write is bit 14 low; short or long frames never reach the registers
    assign write_strobe = frame_done & ~read_write_select;

    // clear faults acts as a one-shot command and is never stored
    assign clear_req = write_strobe && frame_addr == A_PROTECTION_CTRL
                       && frame_wdata[B_CLEAR_FAULTS];

    always_comb begin
        oc_sum   = |fet_oc_q;
        temp_sum = utw_q | otw_q | ots_q;
        ol_sum   = ol_a_q | ol_b_q;
        // warnings and stall only pull the fault pin when reporting is on
        fault_any = serr_q | supply_undervoltage_lockout_q | charge_pump_undervoltage_q | oc_sum | ots_q | ol_sum
                    | ((utw_q | otw_q) & protection_q[B_TW_REPORT])
                    | (stall_q & stall_ol_q[B_STALL_REPORT]);
        fault_summary = {fault_q, serr_q, supply_undervoltage_lockout_q, charge_pump_undervoltage_q,
                         oc_sum, stall_q, temp_sum, ol_sum};
        diag_thermal  = {utw_q, otw_q, ots_q, learn_ok_q,
                         stall_q, 1'b0, ol_b_q, ol_a_q};
        status_byte   = {STATUS_TAG, fault_summary[5:0]};
    end

    // sticky status: a new event in the clearing cycle survives the clear
    always_comb begin
        supply_undervoltage_lockout_d     = sticky_next(supply_undervoltage_lockout_q, SUPPLY_UNDERVOLTAGE_LOCKOUT_IN, clear_req);
        charge_pump_undervoltage_d     = sticky_next(charge_pump_undervoltage_q, CHARGE_PUMP_UNDERVOLTAGE_IN, clear_req);
        serr_d     = sticky_next(serr_q, frame_err, clear_req);
        fet_oc_d   = (fet_oc_q & {8{~clear_req}}) | FET_OVERCURRENT_IN;
        utw_d      = sticky_next(utw_q, UNDERTEMP_WARNING_IN, clear_req);
        otw_d      = sticky_next(otw_q, OVERTEMP_WARNING_IN, clear_req);
        ots_d      = sticky_next(ots_q, OVERTEMP_SHUTDOWN_IN, clear_req);
        learn_ok_d = sticky_next(learn_ok_q, STALL_LEARN_DONE_IN, clear_req);
        stall_d    = sticky_next(stall_q, STALL_IN & stall_ol_q[B_STALL_DETECT],
                                 clear_req);
        ol_a_d     = sticky_next(ol_a_q, OPEN_LOAD_BRIDGE_A_IN & protection_q[B_OL_ENABLE],
                                 clear_req);
        ol_b_d     = sticky_next(ol_b_q, OPEN_LOAD_BRIDGE_B_IN & protection_q[B_OL_ENABLE],
                                 clear_req);
        fault_d    = fault_any;
    end

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            supply_undervoltage_lockout_q     <= 1'b0;
            charge_pump_undervoltage_q     <= 1'b0;
            serr_q     <= 1'b0;
            fet_oc_q   <= '0;
            utw_q      <= 1'b0;
            otw_q      <= 1'b0;
            ots_q      <= 1'b0;
            learn_ok_q <= 1'b0;
            stall_q    <= 1'b0;
            ol_a_q     <= 1'b0;
            ol_b_q     <= 1'b0;
            fault_q    <= 1'b0;
        end else begin
            supply_undervoltage_lockout_q     <= supply_undervoltage_lockout_d;
            charge_pump_undervoltage_q     <= charge_pump_undervoltage_d;
            serr_q     <= serr_d;
            fet_oc_q   <= fet_oc_d;
            utw_q      <= utw_d;
            otw_q      <= otw_d;
            ots_q      <= ots_d;
            learn_ok_q <= learn_ok_d;
            stall_q    <= stall_d;
            ol_a_q     <= ol_a_d;
            ol_b_q     <= ol_b_d;
            fault_q    <= fault_d;
        end
    end

    // control register writes; status, count and revision have no write path
    always_comb begin
        torque_slew_d  = torque_slew_q;
        decay_off_d    = decay_off_q;
        step_dir_d     = step_dir_q;
        protection_d   = protection_q;
        stall_ol_d     = stall_ol_q;
        stall_thresh_d = stall_thresh_q;
        torque_count_d = TORQUE_COUNT_VALUE_IN;
        if (write_strobe) begin
            unique case (frame_addr)
                A_TORQUE_SLEW_CTRL:
                    torque_slew_d = masked_write(torque_slew_q, frame_wdata,
                                                 M_TORQUE_SLEW);
                A_DECAY_OFF_CTRL:
                    decay_off_d = masked_write(decay_off_q, frame_wdata,
                                               M_DECAY_OFF);
                A_STEP_DIR_CTRL:
                    step_dir_d = masked_write(step_dir_q, frame_wdata,
                                              M_STEP_DIR);
                A_PROTECTION_CTRL:
                    protection_d = masked_write(protection_q, frame_wdata,
                                                M_PROTECTION);
                A_STALL_OL_CTRL:
                    stall_ol_d = masked_write(stall_ol_q, frame_wdata,
                                              M_STALL_OL);
                A_STALL_THRESHOLD:
                    stall_thresh_d = masked_write(stall_thresh_q, frame_wdata,
                                                  M_STALL_THRESH);
                // status, torque count, revision and unmapped: write dropped
                default: ;
            endcase
        end
        // learning ends by itself on success, even against a same-cycle write
        if (STALL_LEARN_DONE_IN) stall_ol_d[B_LEARN_START] = 1'b0;
    end

    always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            torque_slew_q  <= RST_TORQUE_SLEW;
            decay_off_q    <= RST_DECAY;
            step_dir_q     <= RST_STEP_DIR;
            protection_q   <= RST_PROTECTION;
            stall_ol_q     <= RST_STALL_OL;
            stall_thresh_q <= RST_STALL_THRESH;
            torque_count_q <= '0;
        end else begin
            torque_slew_q  <= torque_slew_d;
            decay_off_q    <= decay_off_d;
            step_dir_q     <= step_dir_d;
            protection_q   <= protection_d;
            stall_ol_q     <= stall_ol_d;
            stall_thresh_q <= stall_thresh_d;
            torque_count_q <= torque_count_d;
        end
    end

    // report byte: sampled by the frame engine right after the address byte,
    // i.e. before any write of the same frame lands
    always_comb begin
        unique case (frame_addr)
            A_FAULT_SUMMARY:    report_byte = fault_summary;
            A_FET_OC_DIAG:      report_byte = fet_oc_q;
            A_THERM_STALL_DIAG: report_byte = diag_thermal;
            A_TORQUE_SLEW_CTRL: report_byte = torque_slew_q;
            A_DECAY_OFF_CTRL:   report_byte = decay_off_q;
            A_STEP_DIR_CTRL:    report_byte = step_dir_q;
            A_PROTECTION_CTRL:  report_byte = protection_q;
            A_STALL_OL_CTRL:    report_byte = stall_ol_q;
            A_STALL_THRESHOLD:  report_byte = stall_thresh_q;
            A_TORQUE_COUNT:     report_byte = torque_count_q;
            A_REVISION_INFO:    report_byte = {4'h0, REVISION_CODE} & M_REVISION;
            default:            report_byte = '0;
        endcase
    end

    // control fields out to the power stage
    assign FAULT_N_OUT                     = ~fault_q;
    assign TORQUE_SCALE_OUT                = torque_slew_q[7:4];
    assign SLEW_RATE_OUT                   = torque_slew_q[1:0];
    assign OUTPUT_DISABLE_OUT              = decay_off_q[B_OUTPUT_DIS];
    assign PWM_OFF_TIME_OUT                = decay_off_q[4:3];
    assign DECAY_MODE_OUT                  = decay_off_q[2:0];
    assign DIRECTION_OUT                   = step_dir_q[B_DIR];
    assign STEP_OUT                        = step_dir_q[B_STEP];
    assign SERIAL_DIR_SELECT_OUT           = step_dir_q[B_SERIAL_DIR];
    assign SERIAL_STEP_SELECT_OUT          = step_dir_q[B_SERIAL_STEP];
    assign LOCK_OUT                        = protection_q[6:4];
    assign OPEN_LOAD_ENABLE_OUT            = protection_q[B_OL_ENABLE];
    assign OVERCURRENT_RESPONSE_OUT        = protection_q[B_OCP_RESPONSE];
    assign OVERTEMP_RESPONSE_OUT           = protection_q[B_OTS_RESPONSE];
    assign THERMAL_WARN_REPORT_OUT         = protection_q[B_TW_REPORT];
    assign STALL_LEARN_START_OUT           = stall_ol_q[B_LEARN_START];
    assign STALL_DETECT_ENABLE_OUT         = stall_ol_q[B_STALL_DETECT];
    assign STALL_REPORT_ENABLE_OUT         = stall_ol_q[B_STALL_REPORT];
    assign OPEN_LOAD_TIME_OUT              = stall_ol_q[2:1];
    assign DECAY_DRIVE_BLANKING_ENABLE_OUT = stall_ol_q[B_BLANK_EN];
    assign STALL_THRESHOLD_VALUE_OUT       = stall_thresh_q;

endmodule : sdrm_top
`default_nettype wire

// file: src/sdrm_pkg.sv
// constants for the stepper driver register map reached over the serial port
// assumes an 8-bit register file behind a 16-bit serial frame
package sdrm_pkg;

    localparam int          FRAME_BITS    = 16;
    localparam logic [4:0]  FRAME_LEN     = 5'h10;
    localparam logic [4:0]  FRAME_OVER    = 5'h11;
    localparam logic [4:0]  CMD_BITS      = 5'h08;
    localparam int          RW_BIT        = 14;
    localparam int          ADDR_HI       = 13;
    localparam int          ADDR_LO       = 9;
    // address position inside the first byte once 8 bits have arrived
    localparam int          CMD_ADDR_HI   = ADDR_HI - 8;
    localparam int          CMD_ADDR_LO   = ADDR_LO - 8;
    localparam logic [1:0]  STATUS_TAG    = 2'h3;

    localparam logic [4:0]  A_FAULT_SUMMARY     = 5'h00;
    localparam logic [4:0]  A_FET_OC_DIAG       = 5'h01;
    localparam logic [4:0]  A_THERM_STALL_DIAG  = 5'h02;
    localparam logic [4:0]  A_TORQUE_SLEW_CTRL  = 5'h03;
    localparam logic [4:0]  A_DECAY_OFF_CTRL    = 5'h04;
    localparam logic [4:0]  A_STEP_DIR_CTRL     = 5'h05;
    localparam logic [4:0]  A_PROTECTION_CTRL   = 5'h06;
    localparam logic [4:0]  A_STALL_OL_CTRL     = 5'h07;
    localparam logic [4:0]  A_STALL_THRESHOLD   = 5'h08;
    localparam logic [4:0]  A_TORQUE_COUNT      = 5'h09;
    localparam logic [4:0]  A_REVISION_INFO     = 5'h0A;

    // writable bits of each control register; reserved bits stay zero
    localparam logic [7:0]  M_TORQUE_SLEW   = 8'hF3;
    localparam logic [7:0]  M_DECAY_OFF     = 8'h9F;
    localparam logic [7:0]  M_STEP_DIR      = 8'hF0;
    localparam logic [7:0]  M_PROTECTION    = 8'h7F;
    localparam logic [7:0]  M_STALL_OL_BASE = 8'h38;
    localparam logic [7:0]  M_STALL_OL_EXT  = 8'h3F;
    localparam logic [7:0]  M_STALL_THRESH  = 8'hFF;
    localparam logic [7:0]  M_REVISION      = 8'h0F;

    localparam logic [7:0]  RST_TORQUE_SLEW   = 8'h00;
    localparam logic [7:0]  RST_DECAY_BASE    = 8'h00;
    localparam logic [7:0]  RST_DECAY_EXT     = 8'h80;
    localparam logic [7:0]  RST_STEP_DIR      = 8'h00;
    localparam logic [7:0]  RST_PROTECTION    = 8'h00;
    localparam logic [7:0]  RST_STALL_OL      = 8'h00;
    localparam logic [7:0]  RST_STALL_THRESH  = 8'h00;

    // field positions
    localparam int B_FAULT_PIN    = 7;
    localparam int B_SERIAL_ERR   = 6;
    localparam int B_CLEAR_FAULTS = 7;
    localparam int B_OL_ENABLE    = 3;
    localparam int B_TW_REPORT    = 0;
    localparam int B_LEARN_START  = 5;
    localparam int B_STALL_DETECT = 4;
    localparam int B_STALL_REPORT = 3;
    localparam int B_OUTPUT_DIS   = 7;
    localparam int B_DIR          = 7;
    localparam int B_STEP         = 6;
    localparam int B_SERIAL_DIR   = 5;
    localparam int B_SERIAL_STEP  = 4;
    localparam int B_OCP_RESPONSE = 2;
    localparam int B_OTS_RESPONSE = 1;
    localparam int B_BLANK_EN     = 0;

endpackage : sdrm_pkg

// file: src/sdrm_spi_frame.sv
// serial frame engine: samples the serial pins on the system clock, captures
// on falling serial clock, drives on rising serial clock, msb first
// assumes the pins are already synchronous to the system clock
`timescale 1ns/100ps
`default_nettype none
module sdrm_spi_frame
    import sdrm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        sdi_in,
    input  wire logic [7:0]  status_in,
    input  wire logic [7:0]  report_in,
    output logic      [4:0]  addr_out,
    output logic             frame_done_out,
    output logic             frame_err_out,
    output logic             read_write_select_out,
    output logic      [7:0]  wdata_out,
    output logic             sdo_out,
    output logic             sdo_oe_out
);
    import sdrm_pkg::*;

    logic        sclk_q, sclk_d, cs_q, cs_d;
    logic [15:0] shin_q, shin_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [4:0]  idx_q, idx_d;
    logic        load_q, load_d;
    logic [7:0]  stat_q, stat_d, rep_q, rep_d;
    logic        sdo_q, sdo_d, oe_q, oe_d;
    logic        done_q, done_d, err_q, err_d;
    logic        fall, rise, start, stop;

    always_comb begin
        fall   = sclk_q & ~sclk_in;
        rise   = ~sclk_q & sclk_in;
        start  = cs_q & ~cs_n_in;
        stop   = ~cs_q & cs_n_in;
        sclk_d = sclk_in;
        cs_d   = cs_n_in;
        shin_d = shin_q;
        cnt_d  = cnt_q;
        idx_d  = idx_q;
        stat_d = stat_q;
        rep_d  = rep_q;
        load_d = 1'b0;
        done_d = 1'b0;
        err_d  = 1'b0;
        if (start) begin
            cnt_d  = '0;
            idx_d  = '0;
            stat_d = status_in;
            rep_d  = '0;
        end else if (!cs_n_in) begin
            if (fall) begin
                shin_d = {shin_q[14:0], sdi_in};
                if (cnt_q != FRAME_OVER) cnt_d = cnt_q + 5'h01;
                load_d = (cnt_q + 5'h01 == CMD_BITS);
            end
            // the first rise keeps the msb that was set up at select
            if (rise && cnt_q != '0 && idx_q != FRAME_OVER) idx_d = idx_q + 5'h01;
        end
        // the address byte is complete here, so the old contents go out
        if (load_q) rep_d = report_in;
        if (stop) begin
            done_d = (cnt_q == FRAME_LEN);
            err_d  = (cnt_q != FRAME_LEN);
        end
        sdo_d = (idx_q < CMD_BITS) ? stat_q[3'h7 - idx_q[2:0]] : rep_q[3'h7 - idx_q[2:0]];
        oe_d  = ~cs_n_in;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
            shin_q <= '0;
            cnt_q  <= '0;
            idx_q  <= '0;
            load_q <= 1'b0;
            stat_q <= '0;
            rep_q  <= '0;
            sdo_q  <= 1'b0;
            oe_q   <= 1'b0;
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
            cs_q   <= cs_d;
            shin_q <= shin_d;
            cnt_q  <= cnt_d;
            idx_q  <= idx_d;
            load_q <= load_d;
            stat_q <= stat_d;
            rep_q  <= rep_d;
            sdo_q  <= sdo_d;
            oe_q   <= oe_d;
            done_q <= done_d;
            err_q  <= err_d;
        end
    end

    // with exactly 8 bits in, the command byte sits in the low byte; at 16 it sits in the high byte
    assign addr_out              = (cnt_q == FRAME_LEN) ? shin_q[ADDR_HI:ADDR_LO]
                                                        : shin_q[CMD_ADDR_HI:CMD_ADDR_LO];
    assign read_write_select_out = shin_q[RW_BIT];
    assign wdata_out             = shin_q[7:0];
    assign frame_done_out        = done_q;
    assign frame_err_out         = err_q;
    assign sdo_out               = sdo_q;
    assign sdo_oe_out            = oe_q;

endmodule : sdrm_spi_frame
`default_nettype wire

// file: testbench/sdrm_sva.sv
// port checker for the register map
// assumes it is bound into sdrm_top
`timescale 1ns/100ps
`default_nettype none
module sdrm_sva #(parameter bit EXTENDED_VARIANT = 1'b0) (
    input wire logic       CLK_SYS_IN, SYS_RST_IN, CHIP_SELECT_N_IN, SERIAL_DATA_OUT_OUT,
    input wire logic       SERIAL_DATA_OUT_OE_OUT, SUPPLY_UNDERVOLTAGE_LOCKOUT_IN, FAULT_N_OUT,
    input wire logic       STALL_LEARN_DONE_IN, STALL_LEARN_START_OUT, OUTPUT_DISABLE_OUT,
    input wire logic [1:0] OPEN_LOAD_TIME_OUT
);
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    oe_lag_a: assert property (!$past(SYS_RST_IN) |->
        SERIAL_DATA_OUT_OE_OUT == !$past(CHIP_SELECT_N_IN)) else $error("enable lag");
    oe_rel_a: assert property (CHIP_SELECT_N_IN [*2] |-> !SERIAL_DATA_OUT_OE_OUT)
        else $error("enable held");
    hdr_one_a: assert property ($rose(SERIAL_DATA_OUT_OE_OUT) |=> SERIAL_DATA_OUT_OUT)
        else $error("header bit low");
    rst_dis_a: assert property ($fell(SYS_RST_IN) |-> OUTPUT_DISABLE_OUT == EXTENDED_VARIANT)
        else $error("reset default");
    base_ol_a: assert property (!EXTENDED_VARIANT |-> OPEN_LOAD_TIME_OUT == 2'h0)
        else $error("reserved bits set");
    uv_pin_a: assert property (SUPPLY_UNDERVOLTAGE_LOCKOUT_IN |-> ##[1:3] !FAULT_N_OUT)
        else $error("fault pin slow");
    uv_hold_a: assert property ($fell(FAULT_N_OUT) |=> !FAULT_N_OUT [*3])
        else $error("fault not sticky");
    learn_clr_a: assert property (STALL_LEARN_DONE_IN |=> !STALL_LEARN_START_OUT)
        else $error("learn start kept");
    cover property ($rose(SERIAL_DATA_OUT_OE_OUT));
    cover property ($fell(FAULT_N_OUT));
    cover property ($fell(STALL_LEARN_START_OUT));
endmodule : sdrm_sva
bind sdrm_top sdrm_sva #(.EXTENDED_VARIANT(EXTENDED_VARIANT)) i_sva (.*);
`default_nettype wire

// file: testbench/sdrm_spi_master.sv
// serial master standing in for the controller
// assumes the device samples the link on clk_in
`timescale 1ns/100ps
`default_nettype none
module sdrm_spi_master (
    input  wire logic clk_in, sdo_in,
    output var logic  sclk_out, cs_n_out, sdi_out
);
    initial {sclk_out, cs_n_out, sdi_out} = 3'b010;
    // four cycles a half period so every serial edge is seen; n below 16 breaks framing
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 15; i > 15 - n; i--) begin
            sclk_out <= 1'b1;
            sdi_out <= w[i];
            repeat (4) @(posedge clk_in);
            r[i] = sdo_in;
            sclk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
        end
        cs_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
        repeat (6) @(posedge clk_in);
    endtask : xfer
endmodule : sdrm_spi_master
`default_nettype wire

// file: testbench/test_sdrm_top.sv
// bench for serial register traffic and status capture, base variant
// assumes the default revision code of one
`timescale 1ns/100ps
`default_nettype none
module test_sdrm_top;
    logic        clk = 1'b0, rst = 1'b1, uv = 1'b0, tw = 1'b0, stall_summary = 1'b0, lrn = 1'b0;
    logic [7:0]  foc = 8'h00;
    logic [15:0] r;
    wire logic   sclk, cs_n, serial_data_in, serial_data_out;
    wire logic [47:0] cv;
    assign {cv[39:38], cv[31], cv[19:16], cv[14:13], cv[3:2]} = 11'h000;
    int          n_fail = 0, total_checks = 0;
    always #12.5 clk = ~clk;
    sdrm_spi_master i_master (.clk_in(clk), .sdo_in(serial_data_out), .sclk_out(sclk), .cs_n_out(cs_n),
        .sdi_out(serial_data_in));
    sdrm_top i_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .SCLK_IN(sclk), .CHIP_SELECT_N_IN(cs_n),
        .SERIAL_DATA_IN_IN(serial_data_in), .SERIAL_DATA_OUT_OUT(serial_data_out), .SERIAL_DATA_OUT_OE_OUT(),
        .SUPPLY_UNDERVOLTAGE_LOCKOUT_IN(uv), .CHARGE_PUMP_UNDERVOLTAGE_IN(stall_summary),
        .FET_OVERCURRENT_IN(foc), .UNDERTEMP_WARNING_IN(tw), .OVERTEMP_WARNING_IN(tw),
        .OVERTEMP_SHUTDOWN_IN(tw), .STALL_IN(stall_summary), .STALL_LEARN_DONE_IN(lrn),
        .OPEN_LOAD_BRIDGE_A_IN(tw), .OPEN_LOAD_BRIDGE_B_IN(tw), .FAULT_N_OUT(),
        .TORQUE_COUNT_VALUE_IN(8'h5A), .TORQUE_SCALE_OUT(cv[7:4]), .SLEW_RATE_OUT(cv[1:0]),
        .OUTPUT_DISABLE_OUT(cv[15]), .PWM_OFF_TIME_OUT(cv[12:11]), .DECAY_MODE_OUT(cv[10:8]),
        .DIRECTION_OUT(cv[23]), .STEP_OUT(cv[22]), .SERIAL_DIR_SELECT_OUT(cv[21]),
        .SERIAL_STEP_SELECT_OUT(cv[20]), .LOCK_OUT(cv[30:28]), .OPEN_LOAD_ENABLE_OUT(cv[27]),
        .OVERCURRENT_RESPONSE_OUT(cv[26]), .OVERTEMP_RESPONSE_OUT(cv[25]),
        .THERMAL_WARN_REPORT_OUT(cv[24]), .STALL_LEARN_START_OUT(cv[37]),
        .STALL_DETECT_ENABLE_OUT(cv[36]), .STALL_REPORT_ENABLE_OUT(cv[35]),
        .OPEN_LOAD_TIME_OUT(cv[34:33]), .DECAY_DRIVE_BLANKING_ENABLE_OUT(cv[32]),
        .STALL_THRESHOLD_VALUE_OUT(cv[47:40]));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [7:0] e);
        i_master.xfer({1'b0, w, a, 1'b0, d}, 16, r);
        chk(r[7:0], e);
    endtask : acc
    task automatic t_map;
        logic [4:0] ad [9] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h01, 5'h09, 5'h0A};
        logic [7:0] mk [9] = '{8'hF3, 8'h9F, 8'hF0, 8'h7F, 8'h38, 8'hFF, 8'h00, 8'h5A, 8'h01};
        for (int k = 0; k < 9; k++) begin
            acc(1'b0, ad[k], 8'hFF, k < 6 ? 8'h00 : mk[k]);
            if (k < 6) chk(cv[8*k +: 8], mk[k]);
            acc(k > 5, ad[k], 8'h00, mk[k]);
        end
        acc(1'b1, 5'h1F, 8'h00, 8'h00);
        $display("map test done");
    endtask : t_map
    task automatic t_stat;
        acc(1'b0, 5'h07, 8'h38, 8'h00);
        acc(1'b0, 5'h06, 8'h08, 8'h00);
        {uv, tw, stall_summary, lrn, foc} <= 12'hF81;
        @(posedge clk);
        {uv, tw, stall_summary, lrn, foc} <= 12'h000;
        acc(1'b1, 5'h01, 8'h00, 8'h81);
        acc(1'b1, 5'h02, 8'h00, 8'hFB);
        acc(1'b1, 5'h00, 8'h00, 8'hBF);
        chk(r[15:8], 8'hFF);
        chk({7'h00, cv[37]}, 8'h00);
        acc(1'b0, 5'h06, 8'h80, 8'h08);
        acc(1'b1, 5'h00, 8'h00, 8'h00);
        $display("status test done");
    endtask : t_stat
    task automatic t_err;
        i_master.xfer(16'h4000, 8, r);
        acc(1'b1, 5'h00, 8'h00, 8'hC0);
        acc(1'b0, 5'h06, 8'h80, 8'h00);
        $display("frame error test done");
    endtask : t_err
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_map;
        t_stat;
        t_err;
        conclude;
    end
    initial begin
        #1ms;
        n_fail++;
        conclude;
    end
endmodule : test_sdrm_top
`default_nettype wire
